// File: failsafe_timer.sv
// Eighth-second tick divider and fan fail-safe countdown
`timescale 1ns/10ps
`include "host_cmd_regs.svh"
module failsafe_timer
    import host_cmd_pkg::*;
#(
    parameter int FANS = `FAN_COUNT,
    parameter int TICK_CYCLES = `FS_TICK_NS / `CLK_PERIOD_NS
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic load,
    input wire logic [FANS-1:0] load_mask,
    input wire logic [7:0] load_ticks,
    input wire logic refresh,
    output logic [FANS-1:0] fs_mask,
    output logic [FANS-1:0] forced
);

    if (TICK_CYCLES < 1)
    begin : g_bad_tick
        $error("failsafe_timer: TICK_CYCLES must be at least 1");
    end

    typedef struct packed {
        logic [31:0] div;
        logic [7:0] ticks_left;
        logic [7:0] reload;
        logic [FANS-1:0] mask;
        logic [FANS-1:0] forced;
    } timer_state_type;

    timer_state_type s_ff;
    timer_state_type nxt_s;
    logic tick;

    always_comb
    begin
        nxt_s = s_ff;
        tick = (s_ff.div == 32'(TICK_CYCLES - 1));
        nxt_s.div = tick ? '0 : s_ff.div + 32'h1;
        if (tick && s_ff.ticks_left != 8'h00)
        begin
            nxt_s.ticks_left = s_ff.ticks_left - 8'h01;
            if (s_ff.ticks_left == 8'h01)
                nxt_s.forced = s_ff.mask;
        end
        // A power update proves the host alive: restart and release the fans
        if (refresh)
        begin
            nxt_s.div = '0;
            nxt_s.ticks_left = s_ff.reload;
            nxt_s.forced = '0;
        end
        if (load)
        begin
            nxt_s.div = '0;
            nxt_s.mask = load_mask;
            nxt_s.reload = load_ticks;
            nxt_s.ticks_left = load_ticks;
            nxt_s.forced = '0;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            s_ff <= '0;
        else
            s_ff <= nxt_s;
    end

    assign fs_mask = s_ff.mask;
    assign forced = s_ff.forced;

endmodule : failsafe_timer

// File: host_cmd_chk.sv
// Port-level checks of the host command block
`timescale 1ns/10ps
module host_cmd_chk
    import host_cmd_pkg::*;
(
    input wire logic clk, rst_b, cmd_valid, cmd_ready, reply_valid, lcd_valid, sw_op_valid, sw_op_done,
    input cmd_pkt_type cmd, lcd_pkt,
    input reply_pkt_type reply,
    input sw_op_type sw_op,
    input fan_levels_type fan_level,
    input wire logic [3:0] failsafe_mask
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire tk = cmd_valid && cmd_ready;
    wire pv = cmd.data[0] < 8'h65 && cmd.data[1] < 8'h65 && cmd.data[2] < 8'h65 && cmd.data[3] < 8'h65;
    property p_rej;
        tk && cmd.code == 8'h14 && (cmd.len < 5'h02 || cmd.len > 5'h10 || cmd.data[0] > 8'h20 || cmd.data[1] > 8'h0e)
            |=> reply_valid && reply.code == 8'hd4;
    endproperty
    a_rej: assert property (p_rej) else $error("bad transaction accepted");
    property p_dir;
        tk && cmd.code == 8'h14 && cmd.len == 5'h02 && cmd.data[0] == 8'h20 && cmd.data[1] == 8'h00
            |=> !sw_op_valid ##1 reply_valid && reply.len == 5'h00;
    endproperty
    a_dir: assert property (p_dir) else $error("direct transaction not immediate");
    property p_lcd;
        tk && cmd.code == 8'h16 |=> lcd_valid && lcd_pkt == $past(cmd) && reply.code == 8'h56;
    endproperty
    a_lcd: assert property (p_lcd) else $error("raw display packet wrong");
    property p_poll;
        tk && cmd.code == 8'h18 && cmd.len == 5'h00 |=> reply_valid && reply.code == 8'h58 && reply.len == 5'h03;
    endproperty
    a_poll: assert property (p_poll) else $error("poll reply wrong");
    property p_mask;
        tk && cmd.code == 8'h17 && cmd.len == 5'h02 && (cmd.data[0] | cmd.data[1]) < 8'h40 |=> reply.code == 8'h57;
    endproperty
    a_mask: assert property (p_mask) else $error("mask command refused");
    property p_fsm;
        tk && cmd.code == 8'h19 && cmd.len == 5'h02 && cmd.data[0] < 8'h10 && cmd.data[1] != 8'h00
            |=> failsafe_mask == $past(cmd.data[0][3:0]) && reply.code == 8'h59;
    endproperty
    a_fsm: assert property (p_fsm) else $error("fail-safe mask not loaded");
    property p_pow;
        tk && cmd.code == 8'h11 && cmd.len == 5'h04 && pv |-> ##2 fan_level == $past(cmd.data[3:0], 2);
    endproperty
    a_pow: assert property (p_pow) else $error("fan power not applied");
    property p_hold;
        sw_op_valid && !sw_op_done |=> sw_op_valid && $stable(sw_op);
    endproperty
    a_hold: assert property (p_hold) else $error("bus op dropped early");
    c_rej: cover property (p_rej);
    c_poll: cover property (tk && cmd.code == 8'h18);
    c_forced: cover property (failsafe_mask[0] && fan_level[0] == 8'h64);
endmodule : host_cmd_chk
bind host_cmd_keypad_fanfs_owbridge host_cmd_chk host_cmd_chk_i (.*);

// File: host_cmd_keypad_fanfs_owbridge.sv
// Host packet handlers: single-wire bridge, raw display commands, keypad and fan fail-safe
`timescale 1ns/10ps
`include "host_cmd_regs.svh"
module host_cmd_keypad_fanfs_owbridge
    import host_cmd_pkg::*;
#(
    parameter int TICK_CYCLES = `FS_TICK_NS / `CLK_PERIOD_NS
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cmd_valid,
    input cmd_pkt_type cmd,
    output logic cmd_ready,
    output logic reply_valid,
    output reply_pkt_type reply,
    output logic sw_op_valid,
    output sw_op_type sw_op,
    output logic [7:0] sw_op_byte,
    input wire logic sw_op_done,
    input wire logic [7:0] sw_rd_byte,
    input wire logic rom_wr_en,
    input wire logic [4:0] rom_wr_idx,
    input wire logic [63:0] rom_wr_id,
    output logic lcd_valid,
    output cmd_pkt_type lcd_pkt,
    input wire logic [`KEY_COUNT-1:0] keys_raw,
    output logic key_report_valid,
    output key_report_type key_report,
    input wire logic save_boot_state,
    output logic [`KEY_COUNT-1:0] boot_press_mask,
    output logic [`KEY_COUNT-1:0] boot_release_mask,
    output fan_levels_type fan_level,
    output logic [`FAN_COUNT-1:0] failsafe_mask
);

    if (TICK_CYCLES < 1)
    begin : g_bad_tick
        $error("host_cmd: TICK_CYCLES must be at least 1");
    end

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_BUS_RESET = 6'h02,
        ST_ADDR = 6'h04,
        ST_WRITE = 6'h08,
        ST_READ = 6'h10,
        ST_DONE = 6'h20
    } phase_type;

    typedef struct packed {
        phase_type phase;
        cmd_pkt_type cmd;
        logic [3:0] byte_idx;
        logic [3:0] rd_idx;
        logic [`SW_SLOTS-1:0] rom_found;
        logic cmd_ready;
        logic reply_valid;
        reply_pkt_type reply;
        logic sw_op_valid;
        sw_op_type sw_op;
        logic [7:0] sw_op_byte;
        logic lcd_valid;
        cmd_pkt_type lcd_pkt;
        logic [`KEY_COUNT-1:0] press_mask;
        logic [`KEY_COUNT-1:0] release_mask;
        logic [`KEY_COUNT-1:0] boot_press;
        logic [`KEY_COUNT-1:0] boot_release;
        fan_levels_type fan_power;
        fan_levels_type fan_level;
    } main_state_type;

    main_state_type s_ff;
    main_state_type nxt_s;

    // Enumerated addresses; written only by the enumeration logic outside
    logic [63:0] rom_id_mem [0:`SW_SLOTS-1];

    logic take;
    logic sw_ok;
    logic keymask_ok;
    logic poll_ok;
    logic fs_ok;
    logic fan_ok;
    logic poll_clear;
    logic fs_load;
    logic fs_refresh;
    logic [`KEY_COUNT-1:0] held;
    logic [`KEY_COUNT-1:0] pressed_acc;
    logic [`KEY_COUNT-1:0] released_acc;
    logic [`FAN_COUNT-1:0] fs_forced;
    logic [`FAN_COUNT-1:0] fs_mask;
    logic [63:0] rom_sel;
    logic [2:0] rom_byte_sel;
    logic [4:0] wr_total;
    logic [3:0] rd_total;
    sw_op_type op_kind;
    logic [7:0] op_byte;
    logic op_last;

    function automatic logic [7:0] reply_code(input logic [7:0] code, input logic ok);
        reply_code = code | (ok ? `REPLY_ACK_FLAG : `REPLY_ERR_FLAG);
    endfunction : reply_code

    function automatic phase_type phase_after(input logic have_write, input logic [3:0] rd_cnt);
        if (have_write)
            phase_after = ST_WRITE;
        else if (rd_cnt != 4'h0)
            phase_after = ST_READ;
        else
            phase_after = ST_DONE;
    endfunction : phase_after

    always_ff @(posedge clk)
    begin
        if (rom_wr_en)
            rom_id_mem[rom_wr_idx] <= rom_wr_id;
    end

    // Validity of each command, judged on the packet being offered
    always_comb
    begin
        take = s_ff.cmd_ready & cmd_valid;
        sw_ok = (cmd.len >= `SW_MIN_LEN) && (cmd.len <= `SW_MAX_LEN)
            && (cmd.data[0] <= `SW_DIRECT_IDX) && (cmd.data[1] <= `SW_MAX_READ);
        keymask_ok = (cmd.len == `KEY_MASK_LEN)
            && (cmd.data[0] <= `KEY_MASK_MAX) && (cmd.data[1] <= `KEY_MASK_MAX);
        poll_ok = (cmd.len == `KEY_POLL_LEN);
        fs_ok = (cmd.len == `FS_LEN) && (cmd.data[0] <= `FS_MASK_MAX) && (cmd.data[1] != 8'h00);
        fan_ok = (cmd.len == `FAN_POWER_LEN);
        for (int i = 0; i < `FAN_COUNT; i++)
            if (cmd.data[i] > `FAN_LEVEL_MAX)
                fan_ok = 1'b0;
        poll_clear = take && (cmd.code == `CMD_KEY_POLL) && poll_ok;
        fs_load = take && (cmd.code == `CMD_FAILSAFE) && fs_ok;
        fs_refresh = take && (cmd.code == `CMD_FAN_POWER) && fan_ok;
    end

    // What the current bus phase asks of the single-wire engine
    always_comb
    begin
        rom_sel = rom_id_mem[s_ff.cmd.data[0][4:0]];
        rom_byte_sel = 3'(s_ff.byte_idx - 4'h1);
        wr_total = s_ff.cmd.len - `SW_MIN_LEN;
        rd_total = s_ff.cmd.data[1][3:0];
        op_kind = SW_OP_WRITE;
        op_byte = '0;
        op_last = 1'b0;
        case (s_ff.phase)
            ST_BUS_RESET:
            begin
                op_kind = SW_OP_RESET;
                op_last = 1'b1;
            end
            ST_ADDR:
            begin
                // Address goes out lowest byte first, after the match byte
                op_byte = (s_ff.byte_idx == 4'h0) ? `SW_MATCH_ROM : rom_sel[{rom_byte_sel, 3'h0} +: 8];
                op_last = (s_ff.byte_idx == `SW_ROM_BYTES);
            end
            ST_WRITE:
            begin
                op_byte = s_ff.cmd.data[s_ff.byte_idx + 4'h2];
                op_last = ({1'b0, s_ff.byte_idx} + 5'h01 == wr_total);
            end
            ST_READ:
            begin
                op_kind = SW_OP_READ;
                op_last = (s_ff.rd_idx + 4'h1 == rd_total);
            end
            default:
            begin
                op_kind = SW_OP_WRITE;
            end
        endcase
    end

    always_comb
    begin
        nxt_s = s_ff;
        nxt_s.reply_valid = 1'b0;
        nxt_s.lcd_valid = 1'b0;
        if (rom_wr_en)
            nxt_s.rom_found[rom_wr_idx] = 1'b1;
        if (save_boot_state)
        begin
            nxt_s.boot_press = s_ff.press_mask;
            nxt_s.boot_release = s_ff.release_mask;
        end
        case (s_ff.phase)
            ST_IDLE:
            begin
                if (take)
                begin
                    nxt_s.reply_valid = 1'b1;
                    nxt_s.reply = '0;
                    nxt_s.reply.len = `REPLY_EMPTY_LEN;
                    nxt_s.reply.code = reply_code(cmd.code, 1'b0);
                    case (cmd.code)
                        `CMD_SW_XACT:
                        begin
                            nxt_s.reply.code = reply_code(cmd.code, sw_ok);
                            if (sw_ok)
                            begin
                                // Reply is held back until the bus phases finish
                                nxt_s.reply_valid = 1'b0;
                                nxt_s.cmd = cmd;
                                nxt_s.byte_idx = '0;
                                nxt_s.rd_idx = '0;
                                if (cmd.data[0] != `SW_DIRECT_IDX && s_ff.rom_found[cmd.data[0][4:0]])
                                    nxt_s.phase = ST_BUS_RESET;
                                else
                                    nxt_s.phase = phase_after(cmd.len != `SW_MIN_LEN, cmd.data[1][3:0]);
                            end
                        end
                        `CMD_LCD_RAW:
                        begin
                            // No checking: a bad payload can upset the display
                            nxt_s.lcd_valid = 1'b1;
                            nxt_s.lcd_pkt = cmd;
                            nxt_s.reply.code = reply_code(cmd.code, 1'b1);
                        end
                        `CMD_KEY_MASKS:
                        begin
                            nxt_s.reply.code = reply_code(cmd.code, keymask_ok);
                            if (keymask_ok)
                            begin
                                nxt_s.press_mask = cmd.data[0][`KEY_COUNT-1:0];
                                nxt_s.release_mask = cmd.data[1][`KEY_COUNT-1:0];
                            end
                        end
                        `CMD_KEY_POLL:
                        begin
                            nxt_s.reply.code = reply_code(cmd.code, poll_ok);
                            if (poll_ok)
                            begin
                                nxt_s.reply.len = `KEY_POLL_REPLY_LEN;
                                nxt_s.reply.data[0] = 8'(held);
                                nxt_s.reply.data[1] = 8'(pressed_acc);
                                nxt_s.reply.data[2] = 8'(released_acc);
                            end
                        end
                        `CMD_FAILSAFE:
                        begin
                            nxt_s.reply.code = reply_code(cmd.code, fs_ok);
                        end
                        `CMD_FAN_POWER:
                        begin
                            nxt_s.reply.code = reply_code(cmd.code, fan_ok);
                            if (fan_ok)
                                for (int i = 0; i < `FAN_COUNT; i++)
                                    nxt_s.fan_power[i] = cmd.data[i];
                        end
                        default:
                        begin
                            nxt_s.reply.code = reply_code(cmd.code, 1'b0);
                        end
                    endcase
                end
            end
            ST_BUS_RESET, ST_ADDR, ST_WRITE, ST_READ:
            begin
                if (!s_ff.sw_op_valid)
                begin
                    nxt_s.sw_op_valid = 1'b1;
                    nxt_s.sw_op = op_kind;
                    nxt_s.sw_op_byte = op_byte;
                end
                else if (sw_op_done)
                begin
                    nxt_s.sw_op_valid = 1'b0;
                    if (s_ff.phase == ST_READ)
                    begin
                        nxt_s.reply.data[s_ff.rd_idx] = sw_rd_byte;
                        nxt_s.rd_idx = s_ff.rd_idx + 4'h1;
                    end
                    else
                        nxt_s.byte_idx = op_last ? 4'h0 : s_ff.byte_idx + 4'h1;
                    if (op_last)
                    begin
                        case (s_ff.phase)
                            ST_BUS_RESET:
                                nxt_s.phase = ST_ADDR;
                            ST_ADDR:
                                nxt_s.phase = phase_after(wr_total != 5'h00, rd_total);
                            ST_WRITE:
                                nxt_s.phase = phase_after(1'b0, rd_total);
                            default:
                                nxt_s.phase = ST_DONE;
                        endcase
                    end
                end
            end
            ST_DONE:
            begin
                nxt_s.reply_valid = 1'b1;
                nxt_s.reply.code = reply_code(s_ff.cmd.code, 1'b1);
                nxt_s.reply.len = {1'b0, rd_total};
                nxt_s.phase = ST_IDLE;
            end
            default:
            begin
                nxt_s.phase = ST_IDLE;
                nxt_s.sw_op_valid = 1'b0;
            end
        endcase
        nxt_s.cmd_ready = (nxt_s.phase == ST_IDLE);
        for (int i = 0; i < `FAN_COUNT; i++)
            nxt_s.fan_level[i] = fs_forced[i] ? `FAN_LEVEL_MAX : nxt_s.fan_power[i];
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_ff <= '0;
            s_ff.phase <= ST_IDLE;
            s_ff.cmd_ready <= 1'b1;
            s_ff.press_mask <= `KEY_MASK_RESET;
            s_ff.release_mask <= `KEY_MASK_RESET;
            s_ff.boot_press <= `KEY_MASK_RESET;
            s_ff.boot_release <= `KEY_MASK_RESET;
            s_ff.fan_power <= {`FAN_COUNT{`FAN_LEVEL_MAX}};
            s_ff.fan_level <= {`FAN_COUNT{`FAN_LEVEL_MAX}};
        end
        else
            s_ff <= nxt_s;
    end

    key_tracker #(
        .KEYS(`KEY_COUNT)
    ) u_keys (
        .clk(clk),
        .rst_b(rst_b),
        .keys_raw(keys_raw),
        .press_mask(s_ff.press_mask),
        .release_mask(s_ff.release_mask),
        .poll_clear(poll_clear),
        .held(held),
        .pressed_acc(pressed_acc),
        .released_acc(released_acc),
        .report_valid(key_report_valid),
        .report(key_report)
    );

    failsafe_timer #(
        .FANS(`FAN_COUNT),
        .TICK_CYCLES(TICK_CYCLES)
    ) u_failsafe (
        .clk(clk),
        .rst_b(rst_b),
        .load(fs_load),
        .load_mask(cmd.data[0][`FAN_COUNT-1:0]),
        .load_ticks(cmd.data[1]),
        .refresh(fs_refresh),
        .fs_mask(fs_mask),
        .forced(fs_forced)
    );

    assign cmd_ready = s_ff.cmd_ready;
    assign reply_valid = s_ff.reply_valid;
    assign reply = s_ff.reply;
    assign sw_op_valid = s_ff.sw_op_valid;
    assign sw_op = s_ff.sw_op;
    assign sw_op_byte = s_ff.sw_op_byte;
    assign lcd_valid = s_ff.lcd_valid;
    assign lcd_pkt = s_ff.lcd_pkt;
    assign boot_press_mask = s_ff.boot_press;
    assign boot_release_mask = s_ff.boot_release;
    assign fan_level = s_ff.fan_level;
    assign failsafe_mask = fs_mask;

endmodule : host_cmd_keypad_fanfs_owbridge

// File: host_cmd_keypad_fanfs_owbridge_test.sv
// Self-checking bench of the host command block
`timescale 1ns/10ps
module host_cmd_keypad_fanfs_owbridge_test
    import host_cmd_pkg::*;
;
    logic clk = 0, rst_b = 0, cmd_valid = 0, rom_wr_en = 0, save_boot_state = 0, sw_op_valid, sw_op_done;
    logic cmd_ready, reply_valid, lcd_valid, key_report_valid;
    logic [3:0] dly = 4'h0, failsafe_mask;
    logic [5:0] keys_raw = 6'h00, boot_press_mask, boot_release_mask;
    logic [4:0] rom_wr_idx = 5'h03;
    logic [63:0] rom_wr_id = 64'h0807060504030201;
    logic [7:0] sw_op_byte, sw_rd_byte;
    cmd_pkt_type cmd = '0, lcd_pkt;
    reply_pkt_type reply, rp;
    sw_op_type sw_op;
    key_report_type key_report;
    fan_levels_type fan_level;
    int miscompares = 0, checks_done = 0;
    always #4 clk = ~clk;
    host_cmd_keypad_fanfs_owbridge #(.TICK_CYCLES(8)) host_cmd_keypad_fanfs_owbridge_i (.*);
    sw_engine_model sw_engine_model_i (.*);
    task automatic chk(input string s, input logic [31:0] e, g);
        checks_done++;
        if (g !== e)
        begin
            $display("unexpected %s expected %h seen %h", s, e, g);
            miscompares++;
        end
    endtask : chk
    task automatic send(input logic [7:0] c, input logic [4:0] l, input logic [127:0] d, input logic [7:0] ec);
        int n = 0;
        @(negedge clk);
        while (cmd_ready !== 1'b1) @(negedge clk);
        cmd = {c, l, d};
        cmd_valid = 1;
        @(negedge clk);
        cmd_valid = 0;
        while (reply_valid !== 1'b1 && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        rp = reply;
        chk("reply valid", 32'h1, 32'(reply_valid));
        chk("code", ec, rp.code);
    endtask : send
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    initial
    begin
        #20000;
        miscompares++;
        final_report();
    end
    initial
    begin
        repeat (4) @(negedge clk);
        rst_b = 1;
        chk("reset fans", 32'h64646464, fan_level);
        keys_raw = 6'h01;
        for (int i = 0; i < 9 && key_report_valid !== 1'b1; i++) @(negedge clk);
        chk("key report", 4'h8, key_report);
        send(8'h17, 5'h02, 128'h0, 8'h57);
        send(8'h17, 5'h02, 128'h40, 8'hd7);
        keys_raw = 6'h08;
        repeat (8) @(negedge clk);
        chk("masked report", 4'h8, key_report);
        send(8'h18, 5'h00, 128'h0, 8'h58);
        chk("poll", 24'h010908, rp.data[2:0]);
        send(8'h18, 5'h00, 128'h0, 8'h58);
        chk("repoll", 24'h000008, rp.data[2:0]);
        save_boot_state = 1;
        @(negedge clk);
        save_boot_state = 0;
        @(negedge clk);
        chk("boot masks", 12'h0, {boot_press_mask, boot_release_mask});
        send(8'h14, 5'h03, 128'hcc0220, 8'h54);
        chk("bus read", 32'h02005b5a, {3'h0, rp.len, sw_engine_model_i.rs, rp.data[1:0]});
        chk("bus write", 8'hcc, sw_engine_model_i.wq[0]);
        sw_engine_model_i.wq.delete();
        rom_wr_en = 1;
        @(negedge clk);
        rom_wr_en = 0;
        dly = 4'h3;
        send(8'h14, 5'h02, 128'h0003, 8'h54);
        chk("address", 32'h01550809, {sw_engine_model_i.rs, sw_engine_model_i.wq[0], sw_engine_model_i.wq[8],
            8'(sw_engine_model_i.wq.size())});
        send(8'h14, 5'h02, 128'h0020, 8'h54);
        chk("idle bus", 32'h0109, {sw_engine_model_i.rs, 8'(sw_engine_model_i.wq.size())});
        send(8'h14, 5'h01, 128'h0, 8'hd4);
        send(8'h14, 5'h02, 128'h0f00, 8'hd4);
        send(8'h14, 5'h02, 128'h0021, 8'hd4);
        send(8'h16, 5'h05, 128'h1234, 8'h56);
        send(8'h11, 5'h04, 128'h281e140a, 8'h51);
        send(8'h19, 5'h02, 128'h0, 8'hd9);
        send(8'h19, 5'h02, 128'h0205, 8'h59);
        repeat (16) @(negedge clk);
        chk("early", 32'h281e140a, fan_level);
        repeat (1) @(negedge clk);
        chk("forced", 32'h28641464, fan_level);
        send(8'h11, 5'h04, 128'h281e140a, 8'h51);
        repeat (2) @(negedge clk);
        chk("refresh", 32'h281e140a, fan_level);
        repeat (15) @(negedge clk);
        chk("reforced", 32'h28641464, fan_level);
        final_report();
    end
endmodule : host_cmd_keypad_fanfs_owbridge_test

// File: host_cmd_pkg.sv
// Shared packet, bus operation and report types of the host command block
package host_cmd_pkg;

    typedef enum logic [1:0] {SW_OP_RESET = 2'h0, SW_OP_WRITE = 2'h1, SW_OP_READ = 2'h2} sw_op_type;

    typedef struct packed {
        logic [7:0] code;
        logic [4:0] len;
        logic [15:0][7:0] data;
    } cmd_pkt_type;

    typedef struct packed {
        logic [7:0] code;
        logic [4:0] len;
        logic [13:0][7:0] data;
    } reply_pkt_type;

    typedef struct packed {
        logic press;
        logic [2:0] key;
    } key_report_type;

    typedef logic [3:0][7:0] fan_levels_type;

endpackage : host_cmd_pkg

// File: host_cmd_regs.svh
// Command codes, field limits, reset values and timing constants of the host command block
`ifndef HOST_CMD_REGS_SVH
`define HOST_CMD_REGS_SVH

`define CMD_FAN_POWER 8'h11
`define CMD_SW_XACT 8'h14
`define CMD_LCD_RAW 8'h16
`define CMD_KEY_MASKS 8'h17
`define CMD_KEY_POLL 8'h18
`define CMD_FAILSAFE 8'h19

`define REPLY_ACK_FLAG 8'h40
`define REPLY_ERR_FLAG 8'hc0
`define REPLY_EMPTY_LEN 5'h00

`define SW_MIN_LEN 5'h02
`define SW_MAX_LEN 5'h10
`define SW_DIRECT_IDX 8'h20
`define SW_MAX_READ 8'h0e
`define SW_MATCH_ROM 8'h55
`define SW_ROM_BYTES 4'h8
`define SW_SLOTS 32

`define KEY_COUNT 6
`define KEY_UP_BIT 0
`define KEY_ACCEPT_BIT 1
`define KEY_ABORT_BIT 2
`define KEY_WEST_BIT 3
`define KEY_EAST_BIT 4
`define KEY_SOUTH_BIT 5
`define KEY_MASK_LEN 5'h02
`define KEY_MASK_MAX 8'h3f
`define KEY_MASK_RESET 6'h3f
`define KEY_POLL_LEN 5'h00
`define KEY_POLL_REPLY_LEN 5'h03

`define FAN_COUNT 4
`define FS_LEN 5'h02
`define FS_MASK_MAX 8'h0f
`define FAN_POWER_LEN 5'h04
`define FAN_LEVEL_MAX 8'h64

`define CLK_PERIOD_NS 8
`define FS_TICK_NS 125000000

`endif

// File: key_tracker.sv
// Keypad synchroniser, poll accumulators and unsolicited key report queue
`timescale 1ns/10ps
`include "host_cmd_regs.svh"
module key_tracker
    import host_cmd_pkg::*;
#(
    parameter int KEYS = `KEY_COUNT
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [KEYS-1:0] keys_raw,
    input wire logic [KEYS-1:0] press_mask,
    input wire logic [KEYS-1:0] release_mask,
    input wire logic poll_clear,
    output logic [KEYS-1:0] held,
    output logic [KEYS-1:0] pressed_acc,
    output logic [KEYS-1:0] released_acc,
    output logic report_valid,
    output key_report_type report
);

    if (KEYS < 1 || KEYS > 8)
    begin : g_bad_keys
        $error("key_tracker: KEYS must be 1 to 8");
    end

    typedef struct packed {
        logic [KEYS-1:0] sync1;
        logic [KEYS-1:0] sync2;
        logic [KEYS-1:0] held;
        logic [KEYS-1:0] pressed;
        logic [KEYS-1:0] released;
        logic [KEYS-1:0] pend_press;
        logic [KEYS-1:0] pend_release;
        logic report_valid;
        key_report_type report;
    } tracker_state_type;

    tracker_state_type s_ff;
    tracker_state_type nxt_s;
    logic [KEYS-1:0] rise;
    logic [KEYS-1:0] fall;
    logic [KEYS-1:0] take_press;
    logic [KEYS-1:0] take_release;

    function automatic logic [KEYS-1:0] lowest_only(input logic [KEYS-1:0] v);
        lowest_only = v & (~v + {{(KEYS-1){1'b0}}, 1'b1});
    endfunction : lowest_only

    function automatic logic [2:0] key_index(input logic [KEYS-1:0] onehot);
        key_index = '0;
        for (int i = 0; i < KEYS; i++)
            if (onehot[i])
                key_index = 3'(i);
    endfunction : key_index

    always_comb
    begin
        nxt_s = s_ff;
        rise = s_ff.sync2 & ~s_ff.held;
        fall = ~s_ff.sync2 & s_ff.held;
        take_press = lowest_only(s_ff.pend_press);
        take_release = '0;
        nxt_s.sync1 = keys_raw;
        nxt_s.sync2 = s_ff.sync1;
        nxt_s.held = s_ff.sync2;
        // New edges survive a clear in the same cycle
        nxt_s.pressed = (poll_clear ? '0 : s_ff.pressed) | rise;
        nxt_s.released = (poll_clear ? '0 : s_ff.released) | fall;
        nxt_s.report_valid = 1'b0;
        if (take_press != '0)
        begin
            nxt_s.report_valid = 1'b1;
            nxt_s.report.press = 1'b1;
            nxt_s.report.key = key_index(take_press);
        end
        else if (s_ff.pend_release != '0)
        begin
            take_release = lowest_only(s_ff.pend_release);
            nxt_s.report_valid = 1'b1;
            nxt_s.report.press = 1'b0;
            nxt_s.report.key = key_index(take_release);
        end
        nxt_s.pend_press = (s_ff.pend_press & ~take_press) | (rise & press_mask);
        nxt_s.pend_release = (s_ff.pend_release & ~take_release) | (fall & release_mask);
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            s_ff <= '0;
        else
            s_ff <= nxt_s;
    end

    assign held = s_ff.held;
    assign pressed_acc = s_ff.pressed;
    assign released_acc = s_ff.released;
    assign report_valid = s_ff.report_valid;
    assign report = s_ff.report;

endmodule : key_tracker

// File: sw_engine_model.sv
// Single-wire engine stand-in answering byte operations
`timescale 1ns/10ps
module sw_engine_model
    import host_cmd_pkg::*;
(
    input wire logic clk,
    input wire logic [3:0] dly,
    input wire logic sw_op_valid,
    input sw_op_type sw_op,
    input wire logic [7:0] sw_op_byte,
    output logic sw_op_done,
    output logic [7:0] sw_rd_byte
);
    logic [3:0] n = 4'h0;
    logic [7:0] v = 8'h5a;
    logic [7:0] rs = 8'h00;
    logic [7:0] wq[$];
    logic dn = 1'b0;
    // Garbage outside the answer cycle catches late sampling
    assign sw_rd_byte = dn ? v : ~v;
    assign sw_op_done = dn;
    always @(posedge clk)
    begin
        dn <= sw_op_valid && !dn && n == dly;
        n <= (sw_op_valid && !dn && n != dly) ? n + 4'h1 : 4'h0;
        if (dn && sw_op == SW_OP_READ)
            v <= v + 8'h01;
        if (dn && sw_op == SW_OP_WRITE)
            wq.push_back(sw_op_byte);
        if (dn && sw_op == SW_OP_RESET)
            rs <= rs + 8'h01;
    end
endmodule : sw_engine_model
